// [rtl/sdf_core.sv]
/*
  Decimation filters, output coding, result FIFO and serial read-out of result words.
  Assumes MOD_BIT and the setup inputs come from logic on CLK; SCLK and CS_B are pins.
*/
`timescale 1ns/1ps
//==============================================================
// result fifo
module sdf_fifo #(
  parameter int W = 32,
  parameter int D = 8
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp, rp;
  logic [AW:0] cnt;
  logic wr, rd;
  assign in_ready = (cnt != (AW+1)'(D));
  assign out_valid = (cnt != '0);
  assign wr = in_valid & in_ready;
  assign rd = out_valid & out_ready;
  assign out_data = mem[rp];
  always_ff @(posedge CLK) begin
    if (wr) begin
      mem[wp] <= in_data;
    end
  end
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      if (wr) begin
        wp <= (wp == AW'(D-1)) ? '0 : wp + 1'b1;
      end
      if (rd) begin
        rp <= (rp == AW'(D-1)) ? '0 : rp + 1'b1;
      end
      cnt <= cnt + (AW+1)'(wr) - (AW+1)'(rd);
    end
  end
endmodule

//==============================================================
// top
module sdf_core #(
  parameter bit WIDE_CODE = 1'b1
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic MOD_BIT,
  input wire logic [1:0] CHANNEL,
  input wire logic BIPOLAR,
  input wire logic RATE_FAMILY,
  input wire logic [3:0] RATE_SEL,
  input wire logic SCLK,
  input wire logic CS_B,
  output logic SDO_O,
  output logic SDO_OE,
  output logic [31:0] RESULT_WORD,
  output logic RESULT_VALID,
  output logic FIFO_IN_READY
);
  logic [6:0] acc;
  logic tick, clr;
  logic [1:0] last_chan;
  logic [3:0] last_sel;
  logic last_fam;
  logic [3:0] k;

  //==============================================================
  // modulator pacing, all from CLK
  assign k = sdf_pkg::rate_shift(RATE_SEL);
  assign tick = (acc >= 7'(sdf_pkg::MOD_ACC));
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      acc <= '0;
    end else begin
      // 96/6 or 96/5 cycles per sample: 3840 vs 3200 families
      acc <= (tick ? acc - 7'(sdf_pkg::MOD_ACC) : acc)
        + (RATE_FAMILY ? sdf_pkg::MOD_INC_F1 : sdf_pkg::MOD_INC_F0);
    end
  end

  // stale history from another channel would corrupt the next results
  assign clr = (CHANNEL != last_chan) || (RATE_SEL != last_sel) || (RATE_FAMILY != last_fam);
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      last_chan <= '0;
      last_sel <= '0;
      last_fam <= 1'b0;
    end else begin
      last_chan <= CHANNEL;
      last_sel <= RATE_SEL;
      last_fam <= RATE_FAMILY;
    end
  end

  //==============================================================
  // fifth-order comb cascade, ratio 80
  logic signed [sdf_pkg::S5_W-1:0] i5 [sdf_pkg::S5_ORD+1];
  logic signed [sdf_pkg::S5_W-1:0] c5 [sdf_pkg::S5_ORD+1];
  logic signed [sdf_pkg::S5_W-1:0] d5 [sdf_pkg::S5_ORD];
  logic signed [sdf_pkg::S5_W-1:0] s5_out;
  logic [6:0] n5;
  logic s5_dump, s5_vld;
  assign i5[0] = MOD_BIT ? sdf_pkg::S5_W'(1) : -sdf_pkg::S5_W'(1);
  assign s5_dump = tick && (n5 == 7'(sdf_pkg::S5_RATIO - 1));
  assign c5[0] = i5[sdf_pkg::S5_ORD];
  for (genvar g = 0; g < sdf_pkg::S5_ORD; g++) begin : g_s5
    logic signed [sdf_pkg::S5_W-1:0] integ;
    assign i5[g+1] = integ;
    assign c5[g+1] = c5[g] - d5[g];
    always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
        integ <= '0;
        d5[g] <= '0;
      end else if (clr) begin
        integ <= '0;
        d5[g] <= '0;
      end else begin
        if (tick) begin
          integ <= integ + i5[g];
        end
        if (s5_dump) begin
          d5[g] <= c5[g];
        end
      end
    end
  end
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      n5 <= '0;
      s5_vld <= 1'b0;
      s5_out <= '0;
    end else begin
      s5_vld <= s5_dump && !clr;
      if (clr) begin
        n5 <= '0;
      end else if (tick) begin
        n5 <= s5_dump ? '0 : n5 + 1'b1;
      end
      if (s5_dump) begin
        s5_out <= c5[sdf_pkg::S5_ORD];
      end
    end
  end

  // full-scale gain of 80^5 scaled to 2^23; 13-bit multiplier keeps error near 1e-4
  logic signed [sdf_pkg::S5_W+13:0] prod;
  logic signed [sdf_pkg::V_W-1:0] v;
  assign prod = s5_out * $signed({1'b0, sdf_pkg::NORM_MUL});
  assign v = prod[sdf_pkg::NORM_SH +: sdf_pkg::V_W];

  //==============================================================
  // third-order stage, ratio 2^k
  logic signed [sdf_pkg::S3_W-1:0] i3 [sdf_pkg::S3_ORD+1];
  logic signed [sdf_pkg::S3_W-1:0] c3 [sdf_pkg::S3_ORD+1];
  logic signed [sdf_pkg::S3_W-1:0] d3 [sdf_pkg::S3_ORD];
  logic signed [sdf_pkg::S3_W-1:0] s3_sh;
  logic [8:0] n3;
  logic bypass, s3_dump;
  logic signed [sdf_pkg::V_W-1:0] f;
  logic f_vld;
  assign bypass = (k == 4'h0);
  assign i3[0] = sdf_pkg::S3_W'(v);
  assign s3_dump = s5_vld && !bypass && (n3 == 9'((1 << k) - 1));
  assign c3[0] = i3[sdf_pkg::S3_ORD];
  for (genvar g = 0; g < sdf_pkg::S3_ORD; g++) begin : g_s3
    logic signed [sdf_pkg::S3_W-1:0] integ;
    assign i3[g+1] = integ;
    assign c3[g+1] = c3[g] - d3[g];
    always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
        integ <= '0;
        d3[g] <= '0;
      end else if (clr) begin
        integ <= '0;
        d3[g] <= '0;
      end else begin
        if (s5_vld) begin
          integ <= integ + i3[g];
        end
        if (s3_dump) begin
          d3[g] <= c3[g];
        end
      end
    end
  end
  assign s3_sh = c3[sdf_pkg::S3_ORD] >>> (3 * k);
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      n3 <= '0;
      f <= '0;
      f_vld <= 1'b0;
    end else begin
      f_vld <= !clr && (bypass ? s5_vld : s3_dump);
      if (clr) begin
        n3 <= '0;
      end else if (s5_vld) begin
        n3 <= s3_dump ? '0 : n3 + 1'b1;
      end
      f <= bypass ? v : s3_sh[sdf_pkg::V_W-1:0];
    end
  end

  //==============================================================
  // coding and word packing
  logic signed [sdf_pkg::V_W-1:0] u;
  logic ovr;
  logic [sdf_pkg::CODE_W-1:0] code;
  sdf_pkg::sdf_word_t wd;
  assign u = f <<< 1;
  always_comb begin
    if (BIPOLAR) begin
      ovr = (f > sdf_pkg::POS_FS) || (f < sdf_pkg::NEG_FS);
      code = (f > sdf_pkg::POS_FS) ? sdf_pkg::POS_FS[sdf_pkg::CODE_W-1:0]
           : (f < sdf_pkg::NEG_FS) ? sdf_pkg::NEG_FS[sdf_pkg::CODE_W-1:0]
           : f[sdf_pkg::CODE_W-1:0];
    end else begin
      ovr = (f < 0) || (u > sdf_pkg::UNI_FS);
      code = (f < 0) ? '0 : (u > sdf_pkg::UNI_FS) ? sdf_pkg::UNI_FS[sdf_pkg::CODE_W-1:0]
           : u[sdf_pkg::CODE_W-1:0];
    end
  end
  // 16-bit variant keeps the top of the saturated 24-bit code
  assign wd.payload = WIDE_CODE ? {code, 5'h00} : {code[sdf_pkg::CODE_W-1 -: 16], 13'h0000};
  assign wd.overrange_flag = ovr;
  assign wd.channel_tag = last_chan;

  logic fifo_vld, fifo_rd;
  logic [31:0] fifo_dout;
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      RESULT_WORD <= '0;
      RESULT_VALID <= 1'b0;
    end else begin
      RESULT_VALID <= f_vld;
      if (f_vld) begin
        RESULT_WORD <= wd;
      end
    end
  end

  // a full fifo drops the newest word; FIFO_IN_READY shows it
  sdf_fifo #(.W(sdf_pkg::WORD_BITS), .D(sdf_pkg::FIFO_DEPTH)) u_fifo (
    .CLK(CLK),
    .RST_B(RST_B),
    .in_valid(RESULT_VALID),
    .in_ready(FIFO_IN_READY),
    .in_data(RESULT_WORD),
    .out_valid(fifo_vld),
    .out_ready(fifo_rd),
    .out_data(fifo_dout)
  );

  //==============================================================
  // serial read-out
  logic [2:0] sclk_s, cs_s;
  logic fall;
  sdf_pkg::sdf_state_t st;
  logic [sdf_pkg::READ_CLKS-1:0] sh;
  logic [5:0] bits;
  assign fall = sclk_s[2] && !sclk_s[1] && !cs_s[1];
  assign fifo_rd = (st == sdf_pkg::ST_IDLE);
  assign SDO_O = sh[sdf_pkg::READ_CLKS-1];
  assign SDO_OE = !cs_s[1];
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      sclk_s <= '0;
      cs_s <= 3'h7;
    end else begin
      sclk_s <= {sclk_s[1:0], SCLK};
      cs_s <= {cs_s[1:0], CS_B};
    end
  end
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      st <= sdf_pkg::ST_IDLE;
      sh <= '1;
      bits <= '0;
    end else begin
      unique case (st)
        sdf_pkg::ST_IDLE: begin
          if (fifo_vld) begin
            // leading zeros pull the line low: result ready
            sh <= {{sdf_pkg::READY_BITS{1'b0}}, fifo_dout};
            bits <= '0;
            st <= sdf_pkg::ST_READY;
          end
        end
        sdf_pkg::ST_READY, sdf_pkg::ST_SHIFT: begin
          if (fall) begin
            st <= sdf_pkg::ST_SHIFT;
            bits <= bits + 1'b1;
            sh <= {sh[sdf_pkg::READ_CLKS-2:0], 1'b1};
            if (bits == 6'(sdf_pkg::READ_CLKS - 1)) begin
              sh <= '1;
              st <= sdf_pkg::ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  //==============================================================
  // checks
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  property p_zero_bits;
    f_vld |=> (WIDE_CODE ? RESULT_WORD[7:3] == '0 : RESULT_WORD[15:3] == '0);
  endproperty
  a_zero_bits: assert property (p_zero_bits) else $error("unused bits not zero");
  property p_tag;
    f_vld |=> RESULT_WORD[1:0] == $past(last_chan);
  endproperty
  a_tag: assert property (p_tag) else $error("channel tag wrong");
  property p_ovr_bip;
    f_vld && BIPOLAR && f > sdf_pkg::POS_FS |=> RESULT_WORD[2] && RESULT_WORD[31:16] == 16'h7fff;
  endproperty
  a_ovr_bip: assert property (p_ovr_bip) else $error("bipolar top not clamped");
  property p_uni_neg;
    f_vld && !BIPOLAR && f < 0 |=> RESULT_WORD[2] && RESULT_WORD[31:8] == 24'h000000;
  endproperty
  a_uni_neg: assert property (p_uni_neg) else $error("unipolar below zero not flagged");
  property p_bypass;
    s5_vld && bypass && !clr |=> f_vld ##0 f == $past(v);
  endproperty
  a_bypass: assert property (p_bypass) else $error("fast rate not bypassed");
  property p_ratio;
    s5_vld && !bypass |-> n3 <= 9'((1 << k) - 1);
  endproperty
  a_ratio: assert property (p_ratio) else $error("third-order count beyond ratio");
  property p_clear;
    clr |=> g_s5[0].integ == '0 && n5 == '0 && n3 == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("history kept on channel change");
  property p_tick;
    tick |=> !tick;
  endproperty
  a_tick: assert property (p_tick) else $error("modulator pace too fast");
  property p_msb;
    st == sdf_pkg::ST_SHIFT && fall && bits == 6'(sdf_pkg::READY_BITS - 1)
      |=> SDO_O == $past(sh[sdf_pkg::READ_CLKS-2]);
  endproperty
  a_msb: assert property (p_msb) else $error("word msb not first");
  c_read: cover property (st == sdf_pkg::ST_SHIFT && fall && bits == 6'(sdf_pkg::READ_CLKS - 1));
  c_fast: cover property (f_vld && bypass);
  c_slow: cover property (f_vld && !bypass);
  c_full: cover property (!FIFO_IN_READY);
endmodule

// [common/sdf_pkg.sv]
/*
  Shared constants, word layout and state codes of the decimator and result-word block.
  Assumes a master clock that also paces the modulator, and a host that reads over a serial port.
*/
//==============================================================
package sdf_pkg;
  localparam int MOD_ACC = 96;
  localparam logic [6:0] MOD_INC_F0 = 7'h06;
  localparam logic [6:0] MOD_INC_F1 = 7'h05;
  localparam int S5_RATIO = 80;
  localparam int S5_ORD = 5;
  localparam int S5_W = 34;
  localparam int S3_ORD = 3;
  localparam int V_W = 26;
  localparam int S3_W = V_W + 27;
  localparam logic [12:0] NORM_MUL = 13'h0a7c;
  localparam int NORM_SH = 20;
  localparam int CODE_W = 24;
  localparam logic signed [V_W-1:0] POS_FS = 26'sh07fffff;
  localparam logic signed [V_W-1:0] NEG_FS = -26'sh0800000;
  localparam logic signed [V_W-1:0] UNI_FS = 26'sh0ffffff;
  localparam int READY_BITS = 8;
  localparam int WORD_BITS = 32;
  localparam int READ_CLKS = READY_BITS + WORD_BITS;
  localparam int FIFO_DEPTH = 8;

  typedef struct packed {
    logic [28:0] payload;
    logic overrange_flag;
    logic [1:0] channel_tag;
  } sdf_word_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_READY = 3'b010,
    ST_SHIFT = 3'b100
  } sdf_state_t;

  // log2 of the third-order ratio; zero means bypassed
  function automatic logic [3:0] rate_shift(input logic [3:0] sel);
    case (sel)
      4'h1: rate_shift = 4'h6;
      4'h2: rate_shift = 4'h7;
      4'h3: rate_shift = 4'h8;
      4'h4: rate_shift = 4'h9;
      4'h8: rate_shift = 4'h0;
      4'h9: rate_shift = 4'h1;
      4'ha: rate_shift = 4'h2;
      4'hb: rate_shift = 4'h3;
      4'hc: rate_shift = 4'h4;
      default: rate_shift = 4'h5;
    endcase
  endfunction
endpackage

// [tb/sdf_host_model.sv]
/*
  Host model that reads result words from the block over the serial port.
  Assumes the bench raises hold to stall reads; SCLK rests low outside frames.
*/
`timescale 1ns/1ps
//==============================================================
// host reader
module sdf_host_model (
  input wire logic hold,
  input wire logic sdo_o,
  input wire logic sdo_oe,
  output logic sclk,
  output logic cs_b,
  output logic [31:0] word,
  output logic done
);
  // no pull on the line: a released output reads inverted so a stale bit cannot pass
  logic line;
  assign line = sdo_oe ? sdo_o : !sdo_o;
  initial begin
    sclk = 1'b0;
    cs_b = 1'b1;
    word = 32'h0;
    done = 1'b0;
    forever begin
      #200;
      if (!hold) begin
        cs_b = 1'b0;
        // select must pass the two sync flops before ready is visible
        #100;
        if (sdo_oe === 1'b1 && line === 1'b0) begin
          for (int i = 0; i < 40; i++) begin
            #62.5 sclk = 1'b1;
            if (i >= 8) word = {word[30:0], line};
            #62.5 sclk = 1'b0;
          end
          // let the block return to idle before the bench pops its copy
          #62.5 done = 1'b1;
          #8 done = 1'b0;
        end
        cs_b = 1'b1;
      end
    end
  end
endmodule

// [tb/sdf_core_tb_top.sv]
/*
  Bench for the decimator and result-word block: both code widths, rates, fifo and serial read-out.
  Assumes the host model in its own file; the run stays under about 90000 clock cycles.
*/
`timescale 1ns/1ps
//==============================================================
// bench
module sdf_core_tb_top;
  logic CLK = 1'b0;
  logic RST_B = 1'b0;
  logic MOD_BIT = 1'b0;
  logic [1:0] CHANNEL = 2'h0;
  logic BIPOLAR = 1'b0;
  logic RATE_FAMILY = 1'b0;
  logic [3:0] RATE_SEL = 4'h8;
  logic hold = 1'b1;
  logic sclk, cs_b, sdo_o, sdo_oe, rd_done, fifo_in_ready, res_valid, nar_valid;
  logic [31:0] res_word, nar_word, rd_word;
  logic [31:0] exp_q[$];
  int fail_count = 0;
  int checked = 0;
  int cyc = 0;
  int occ = 0;
  int duty = 0;
  int k;
  longint t0;
  // top twelve code bits near full scale after the 2684/2^20 scaling
  int cf_duty[5] = '{0, 0, 1, 1, 2};
  logic cf_bip[5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
  int cf_top[5] = '{12'h000, 12'h800, 12'h7ff, 12'hfff, 12'h7ff};
  int cf_of[5] = '{1, 0, 0, 0, 0};

  always #4 CLK = ~CLK;

  sdf_core #(.WIDE_CODE(1'b1)) sdf_core_inst (.CLK(CLK), .RST_B(RST_B), .MOD_BIT(MOD_BIT),
    .CHANNEL(CHANNEL), .BIPOLAR(BIPOLAR), .RATE_FAMILY(RATE_FAMILY), .RATE_SEL(RATE_SEL),
    .SCLK(sclk), .CS_B(cs_b), .SDO_O(sdo_o), .SDO_OE(sdo_oe), .RESULT_WORD(res_word),
    .RESULT_VALID(res_valid), .FIFO_IN_READY(fifo_in_ready));
  sdf_core #(.WIDE_CODE(1'b0)) sdf_core_narrow_inst (.CLK(CLK), .RST_B(RST_B), .MOD_BIT(MOD_BIT),
    .CHANNEL(CHANNEL), .BIPOLAR(BIPOLAR), .RATE_FAMILY(RATE_FAMILY), .RATE_SEL(RATE_SEL),
    .SCLK(1'b0), .CS_B(1'b1), .SDO_O(), .SDO_OE(), .RESULT_WORD(nar_word),
    .RESULT_VALID(nar_valid), .FIFO_IN_READY());
  sdf_host_model sdf_host_model_inst (.hold(hold), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .sclk(sclk),
    .cs_b(cs_b), .word(rd_word), .done(rd_done));

  //==============================================================
  // checking and closing
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic wait_res(input bit judge);
    do @(posedge CLK); while (res_valid !== 1'b1);
    chk({31'h0, nar_valid}, 32'h1);
    chk({27'h0, res_word[7:3]}, 32'h0);
    chk({19'h0, nar_word[15:3]}, 32'h0);
    chk({30'h0, res_word[1:0]}, {30'h0, CHANNEL});
    chk({30'h0, nar_word[1:0]}, {30'h0, CHANNEL});
    if (judge) begin
      chk({20'h0, res_word[31:20]}, cf_top[k]);
      chk({20'h0, nar_word[31:20]}, cf_top[k]);
      chk({31'h0, res_word[2]}, cf_of[k]);
      chk({31'h0, nar_word[2]}, cf_of[k]);
    end
  endtask

  //==============================================================
  // stimulus, fifo model and timeout
  always @(posedge CLK) begin
    #1;
    cyc++;
    // three quarters ones: each 16-cycle pace tick sees one whole slot
    MOD_BIT = (duty == 2) ? (cyc % 64 < 48) : duty[0];
    if (cyc == 90000) begin
      fail_count++;
      final_report();
    end
  end

  // one word waits in the shifter besides the eight in the fifo
  always @(posedge CLK) begin
    if (res_valid === 1'b1 && occ < 9) begin
      exp_q.push_back(res_word);
      occ++;
    end
  end

  always @(posedge rd_done) begin
    chk(rd_word, exp_q.pop_front());
    chk({27'h0, rd_word[7:3]}, 32'h0);
    occ--;
  end

  //==============================================================
  // tests
  initial begin
    void'($urandom(32'h80f9));
    repeat (8) @(posedge CLK);
    #1 RST_B = 1'b1;
    CHANNEL = 2'($urandom_range(3));
    k = 0;
    repeat (10) wait_res(1'b0);
    repeat (2) @(posedge CLK);
    chk({31'h0, fifo_in_ready}, 32'h0);
    chk({30'h0, sdo_oe, sdo_o}, 32'h0);
    #1 hold = 1'b0;
    $display("test fifo done");
    for (k = 0; k < 4; k++) begin
      #1;
      RATE_FAMILY = k[1];
      RATE_SEL = {3'b100, k[0]};
      CHANNEL = 2'($urandom_range(3));
      repeat (2) wait_res(1'b0);
      t0 = $time;
      wait_res(1'b0);
      chk(32'(($time - t0) / 8), (1280 << k[0]) * (k[1] ? 6 : 5) / 5);
      $display("test rate %0d done", k);
    end
    for (k = 0; k < 5; k++) begin
      #1;
      RATE_FAMILY = 1'b0;
      RATE_SEL = 4'h8;
      duty = cf_duty[k];
      BIPOLAR = cf_bip[k];
      CHANNEL = 2'(k);
      repeat (5) wait_res(1'b0);
      wait_res(1'b1);
      $display("test data %0d done", k);
    end
    while (occ > 0) @(posedge CLK);
    chk({31'h0, fifo_in_ready}, 32'h1);
    final_report();
  end
endmodule
